// ---- verilog/fso_security_core.sv ----
`timescale 1ns/1ns
module fso_security_core (
    // Clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // Register bus write side
    input  wire logic                  awvalid,
    output logic                       awready,
    input  wire logic [17:0]           awaddr,
    input  wire logic                  wvalid,
    output logic                       wready,
    input  wire logic [31:0]           wdata,
    input  wire logic [3:0]            wstrb,
    output logic                       bvalid,
    input  wire logic                  bready,
    output logic [1:0]                 bresp,
    // Register bus read side
    input  wire logic                  arvalid,
    output logic                       arready,
    input  wire logic [17:0]           araddr,
    output logic                       rvalid,
    input  wire logic                  rready,
    output logic [31:0]                rdata,
    output logic [1:0]                 rresp,
    // Origin of the current bus write
    input  wire logic                  dbg_master,
    input  wire logic                  exec_secure,
    // RAM access gate
    input  wire fso_pkg::fso_ram_req_s ram_req,
    output logic                       ram_grant,
    output logic                       ram_block,
    // Security state
    output logic                       secured
);
    import fso_pkg::*;

    // Erased array at power-up; contents survive every reset
    logic [7:0]  nv_mem [NV_BYTES] = '{default: ERASED};
    logic        aw_hold, next_aw_hold, w_hold, next_w_hold, wlane, next_wlane;
    logic [15:0] waddr, next_waddr, fl_addr, next_fl_addr;
    logic [7:0]  wbyte, next_wbyte, fl_data, next_fl_data;
    logic [7:0]  clk_div, next_clk_div, opt_work, next_opt_work;
    logic [7:0]  config_reg, next_config_reg, prot_work, next_prot_work;
    logic [7:0]  cmd, next_cmd, nv_val;
    logic [7:0]  key_hit, next_key_hit;
    logic        acc_err, next_acc_err, blank_flag, next_blank_flag;
    logic        key_fail, next_key_fail, unlock_key, next_unlock_key;
    logic        unlock_blank, next_unlock_blank;
    fso_seq_e    seq, next_seq;
    logic        next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0]  next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic        next_ram_grant, next_ram_block, next_secured;
    logic        sec_eng, do_wr, wr_en, acc_set, launch, nv_blank;
    logic        nv_erase, nv_prog, key_bad, dbg_bad_cmd;
    logic [3:0]  nv_slot;
    logic [2:0]  kidx;

    // Index that answers on the bus
    function automatic logic fso_mapped(input logic [15:0] idx);
        return idx == IDX_CLK_DIV || idx == IDX_OPT_WORK || idx == IDX_CONFIG
            || idx == IDX_PROT_WORK || idx == IDX_STATUS || idx == IDX_CMD
            || idx >= IDX_FLASH_BASE;
    endfunction : fso_mapped

    // One of the five accepted command codes
    function automatic logic fso_cmd_valid(input logic [7:0] code);
        return code == CMD_BLANK || code == CMD_PROG || code == CMD_BURST
            || code == CMD_PAGE || code == CMD_MASS;
    endfunction : fso_cmd_valid

    // Whole nonvolatile area still erased
    always_comb begin
        nv_blank = 1'b1;
        for (int i = 0; i < NV_BYTES; i++) begin
            nv_blank = nv_blank && (nv_mem[i] == ERASED);
        end
    end

    // Bus slave, command sequence, key entry and gating
    always_comb begin
        next_aw_hold      = aw_hold;
        next_w_hold       = w_hold;
        next_waddr        = waddr;
        next_wbyte        = wbyte;
        next_wlane        = wlane;
        next_clk_div      = clk_div;
        next_opt_work     = opt_work;
        next_config_reg   = config_reg;
        next_prot_work    = prot_work;
        next_cmd          = cmd;
        next_fl_addr      = fl_addr;
        next_fl_data      = fl_data;
        next_acc_err      = acc_err;
        next_blank_flag   = blank_flag;
        next_key_hit      = key_hit;
        next_key_fail     = key_fail;
        next_unlock_key   = unlock_key;
        next_unlock_blank = unlock_blank;
        next_seq          = seq;
        next_bvalid       = bvalid;
        next_bresp        = bresp;
        next_rvalid       = rvalid;
        next_rdata        = rdata;
        next_rresp        = rresp;
        acc_set           = 1'b0;
        launch            = 1'b0;
        nv_erase          = 1'b0;
        nv_prog           = 1'b0;
        nv_slot           = fl_addr[3:0];
        nv_val            = fl_data;
        key_bad           = 1'b0;
        dbg_bad_cmd       = 1'b0;
        kidx              = waddr[2:0];
        sec_eng = (opt_work[1:0] != SEC_UNSECURED) && !unlock_key && !unlock_blank;
        // Address and data are taken in either order
        if (awvalid && awready) begin
            next_aw_hold = 1'b1;
            next_waddr   = awaddr[17:2];
        end
        if (wvalid && wready) begin
            next_w_hold = 1'b1;
            next_wbyte  = wdata[7:0];
            next_wlane  = wstrb[0];
        end
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        do_wr = aw_hold && w_hold && !bvalid;
        wr_en = do_wr && wlane && fso_mapped(waddr);
        if (do_wr) begin
            next_aw_hold = 1'b0;
            next_w_hold  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = fso_mapped(waddr) ? RESP_OKAY : RESP_SLVERR;
        end
        // Register write effects
        if (wr_en) begin
            if (waddr == IDX_STATUS) begin
                if (wbyte[ACCERR_BIT]) begin
                    next_acc_err = 1'b0;
                end
                if (wbyte[LAUNCH_BIT] && seq == SEQ_CMD) begin
                    launch   = 1'b1;
                    next_seq = SEQ_IDLE;
                end else if (seq != SEQ_IDLE) begin
                    acc_set = 1'b1;
                end
            end else if (seq == SEQ_CMD) begin
                acc_set = 1'b1;
            end else if (waddr == IDX_CMD) begin
                if (seq != SEQ_ADDR || !fso_cmd_valid(wbyte)) begin
                    acc_set = 1'b1;
                end else if (dbg_master && sec_eng && wbyte != CMD_BLANK
                             && wbyte != CMD_MASS) begin
                    dbg_bad_cmd = 1'b1;
                    acc_set     = 1'b1;
                end else begin
                    next_cmd = wbyte;
                    next_seq = SEQ_CMD;
                end
            end else if (seq == SEQ_ADDR) begin
                acc_set = 1'b1;
            end else if (waddr == IDX_CLK_DIV) begin
                if (!clk_div[DIVLD_BIT] && !acc_err) begin
                    next_clk_div = {1'b1, wbyte[6:0]};
                end
            end else if (waddr == IDX_CONFIG) begin
                next_config_reg = wbyte & (8'h01 << KEYACC_BIT);
            end else if (waddr == IDX_PROT_WORK) begin
                next_prot_work = wbyte;
            end else if (waddr[15:3] == IDX_KEY[15:3] && config_reg[KEYACC_BIT]) begin
                if (!opt_work[KEY_ENABLE_BIT_BIT]) begin
                    key_bad = 1'b0;
                end else if (dbg_master || !exec_secure) begin
                    key_bad = 1'b1;
                    acc_set = 1'b1;
                end else if (wbyte == nv_mem[{1'b0, kidx}]) begin
                    next_key_hit[kidx] = 1'b1;
                end else begin
                    next_key_fail = 1'b1;
                end
            end else if (waddr >= IDX_FLASH_BASE) begin
                if (!clk_div[DIVLD_BIT] || acc_err) begin
                    acc_set = 1'b1;
                end else begin
                    next_fl_addr = waddr;
                    next_fl_data = wbyte;
                    next_seq     = SEQ_ADDR;
                end
            end
        end
        // Error set wins over a clear in the same cycle
        if (acc_set) begin
            next_acc_err = 1'b1;
            next_seq     = SEQ_IDLE;
        end
        if (&key_hit && !key_fail && opt_work[KEY_ENABLE_BIT_BIT]) begin
            next_unlock_key = 1'b1;
        end
        // Command execution in one cycle
        if (launch) begin
            next_blank_flag = 1'b0;
            case (cmd)
                CMD_BLANK: begin
                    next_blank_flag   = nv_blank;
                    next_unlock_blank = nv_blank || unlock_blank;
                end
                CMD_MASS: begin
                    nv_erase = 1'b1;
                end
                CMD_PAGE: begin
                    nv_erase = fl_addr[15:PAGE_SHIFT] == IDX_NV_BASE[15:PAGE_SHIFT];
                end
                CMD_PROG, CMD_BURST: begin
                    nv_prog = fl_addr[15:4] == IDX_NV_BASE[15:4];
                end
                default: begin
                    nv_prog = 1'b0;
                end
            endcase
        end
        // Read channel
        if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rresp  = fso_mapped(araddr[17:2]) ? RESP_OKAY : RESP_SLVERR;
            next_rdata  = 32'h0000_0000;
            case (araddr[17:2])
                IDX_CLK_DIV:   next_rdata[7:0] = clk_div;
                IDX_OPT_WORK:  next_rdata[7:0] = {opt_work[7:2],
                                                  sec_eng ? opt_work[1:0] : SEC_UNSECURED};
                IDX_CONFIG:    next_rdata[7:0] = config_reg;
                IDX_PROT_WORK: next_rdata[7:0] = prot_work;
                IDX_STATUS:    next_rdata[7:0] = {2'h3, 1'b0, acc_err, 1'b0, blank_flag, 2'h0};
                IDX_CMD:       next_rdata[7:0] = cmd;
                default: begin
                    if (araddr[17:6] == IDX_NV_BASE[15:4]) begin
                        next_rdata[7:0] = nv_mem[araddr[5:2]];
                    end else if (araddr[17:2] >= IDX_FLASH_BASE) begin
                        next_rdata[7:0] = ERASED;
                    end
                end
            endcase
        end
        next_awready = !next_aw_hold;
        next_wready  = !next_w_hold;
        next_arready = !next_rvalid;
        next_ram_grant = ram_req.req && !(sec_eng && (ram_req.from_debug
                                                      || !ram_req.code_secure));
        next_ram_block = ram_req.req && !next_ram_grant;
        next_secured   = sec_eng;
    end

    // Nonvolatile bytes in the flash array
    always_ff @(posedge aclk) begin
        for (int i = 0; i < NV_BYTES; i++) begin
            if (nv_erase) begin
                nv_mem[i] <= ERASED;
            end else if (nv_prog && nv_slot == 4'(i)) begin
                nv_mem[i] <= nv_mem[i] & nv_val;
            end
        end
    end

    // State registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            opt_work     <= nv_mem[NV_OPT_SLOT];
            prot_work    <= nv_mem[NV_PROT_SLOT];
            aw_hold      <= 1'b0;
            w_hold       <= 1'b0;
            waddr        <= 16'h0000;
            wbyte        <= 8'h00;
            wlane        <= 1'b0;
            clk_div      <= CLK_DIV_RST;
            config_reg   <= CONFIG_RST;
            cmd          <= CMD_RST;
            fl_addr      <= 16'h0000;
            fl_data      <= 8'h00;
            acc_err      <= 1'b0;
            blank_flag   <= 1'b0;
            key_hit      <= 8'h00;
            key_fail     <= 1'b0;
            unlock_key   <= 1'b0;
            unlock_blank <= 1'b0;
            seq          <= SEQ_IDLE;
            awready      <= 1'b0;
            wready       <= 1'b0;
            bvalid       <= 1'b0;
            bresp        <= RESP_OKAY;
            arready      <= 1'b0;
            rvalid       <= 1'b0;
            rdata        <= 32'h0000_0000;
            rresp        <= RESP_OKAY;
            ram_grant    <= 1'b0;
            ram_block    <= 1'b0;
            secured      <= 1'b1;
        end else begin
            opt_work     <= next_opt_work;
            prot_work    <= next_prot_work;
            aw_hold      <= next_aw_hold;
            w_hold       <= next_w_hold;
            waddr        <= next_waddr;
            wbyte        <= next_wbyte;
            wlane        <= next_wlane;
            clk_div      <= next_clk_div;
            config_reg   <= next_config_reg;
            cmd          <= next_cmd;
            fl_addr      <= next_fl_addr;
            fl_data      <= next_fl_data;
            acc_err      <= next_acc_err;
            blank_flag   <= next_blank_flag;
            key_hit      <= next_key_hit;
            key_fail     <= next_key_fail;
            unlock_key   <= next_unlock_key;
            unlock_blank <= next_unlock_blank;
            seq          <= next_seq;
            awready      <= next_awready;
            wready       <= next_wready;
            bvalid       <= next_bvalid;
            bresp        <= next_bresp;
            arready      <= next_arready;
            rvalid       <= next_rvalid;
            rdata        <= next_rdata;
            rresp        <= next_rresp;
            ram_grant    <= next_ram_grant;
            ram_block    <= next_ram_block;
            secured      <= next_secured;
        end
    end

    // Checks on one clock, off during reset
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_reset_load;
        $rose(aresetn) |-> opt_work == nv_mem[NV_OPT_SLOT] && prot_work == nv_mem[NV_PROT_SLOT];
    endproperty
    a_reset_load: assert property (p_reset_load) else $error("working bytes not reloaded");

    property p_key_enabled;
        $rose(unlock_key) |-> $past(opt_work[KEY_ENABLE_BIT_BIT]) && $past(&key_hit);
    endproperty
    a_key_enabled: assert property (p_key_enabled) else $error("key unlock without enable");

    property p_key_src;
        key_bad |=> acc_err && $stable(key_hit) && $stable(key_fail);
    endproperty
    a_key_src: assert property (p_key_src) else $error("foreign key write accepted");

    property p_key_off;
        !opt_work[KEY_ENABLE_BIT_BIT] |-> !unlock_key;
    endproperty
    a_key_off: assert property (p_key_off) else $error("disabled key unlocked");

    property p_blank_unlock;
        $rose(unlock_blank) |-> $past(launch) && $past(cmd) == CMD_BLANK && nv_blank;
    endproperty
    a_blank_unlock: assert property (p_blank_unlock) else $error("unlock without blank");

    property p_unsecured;
        opt_work[1:0] == SEC_UNSECURED |=> !secured;
    endproperty
    a_unsecured: assert property (p_unsecured) else $error("unsecured field ignored");

    property p_ram_gate;
        ram_req.req && sec_eng && ram_req.from_debug |=> !ram_grant && ram_block;
    endproperty
    a_ram_gate: assert property (p_ram_gate) else $error("secured RAM reached");

    sequence s_refused;
        ##1 (acc_err && seq == SEQ_IDLE && $stable(cmd)) ##1 acc_err;
    endsequence
    property p_dbg_cmd;
        dbg_bad_cmd |-> s_refused;
    endproperty
    a_dbg_cmd: assert property (p_dbg_cmd) else $error("debug command not refused");

    property p_key_match;
        $rose(unlock_key) |-> !$past(key_fail);
    endproperty
    a_key_match: assert property (p_key_match) else $error("mismatched key unlocked");
endmodule : fso_security_core

// ---- verilog/fso_pkg.sv ----
package fso_pkg;
    // Register indices; the byte address is four times the index
    localparam logic [15:0] IDX_CLK_DIV    = 16'h1820;
    localparam logic [15:0] IDX_OPT_WORK   = 16'h1821;
    localparam logic [15:0] IDX_CONFIG     = 16'h1823;
    localparam logic [15:0] IDX_PROT_WORK  = 16'h1824;
    localparam logic [15:0] IDX_STATUS     = 16'h1825;
    localparam logic [15:0] IDX_CMD        = 16'h1826;
    localparam logic [15:0] IDX_KEY        = 16'hffb0;
    localparam logic [15:0] IDX_NV_PROT    = 16'hffbd;
    localparam logic [15:0] IDX_NV_OPT     = 16'hffbf;
    localparam logic [15:0] IDX_NV_BASE    = 16'hffb0;
    localparam logic [15:0] IDX_FLASH_BASE = 16'h8000;

    // Nonvolatile area geometry
    localparam int          NV_BYTES     = 16;
    localparam int          KEY_BYTES    = 8;
    localparam int          PAGE_BYTES   = 512;
    localparam int          PAGE_SHIFT   = $clog2(PAGE_BYTES);
    localparam logic [3:0]  NV_PROT_SLOT = IDX_NV_PROT[3:0];
    localparam logic [3:0]  NV_OPT_SLOT  = IDX_NV_OPT[3:0];

    // Field positions
    localparam int          KEY_ENABLE_BIT_BIT  = 7;
    localparam int          KEYACC_BIT = 5;
    localparam int          LAUNCH_BIT = 7;
    localparam int          ACCERR_BIT = 4;
    localparam int          BLANK_BIT  = 2;
    localparam int          DIVLD_BIT  = 7;
    localparam logic [1:0]  SEC_UNSECURED = 2'h2;

    // Values after reset and erased content
    localparam logic [7:0]  CLK_DIV_RST = 8'h00;
    localparam logic [7:0]  CONFIG_RST  = 8'h00;
    localparam logic [7:0]  CMD_RST     = 8'h00;
    localparam logic [7:0]  ERASED      = 8'hff;

    // Flash command codes
    localparam logic [7:0]  CMD_BLANK = 8'h05;
    localparam logic [7:0]  CMD_PROG  = 8'h20;
    localparam logic [7:0]  CMD_BURST = 8'h25;
    localparam logic [7:0]  CMD_PAGE  = 8'h40;
    localparam logic [7:0]  CMD_MASS  = 8'h41;

    // Bus responses
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // Command sequence states
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_ADDR = 3'b010,
        SEQ_CMD  = 3'b100
    } fso_seq_e;

    // RAM access request
    typedef struct packed {
        logic req;
        logic from_debug;
        logic code_secure;
    } fso_ram_req_s;
endpackage : fso_pkg

// ---- testbench/fso_bus_host.sv ----
`timescale 1ns/1ns
// Register bus master standing for CPU code and the debug port
module fso_bus_host (
    // Clock
    input  wire logic        aclk,
    // Write side
    output logic             awvalid,
    input  wire logic        awready,
    output logic [17:0]      awaddr,
    output logic             wvalid,
    input  wire logic        wready,
    output logic [31:0]      wdata,
    input  wire logic        bvalid,
    output logic             bready,
    // Read side
    output logic             arvalid,
    input  wire logic        arready,
    output logic [17:0]      araddr,
    input  wire logic        rvalid,
    output logic             rready
);
    // Bus idle at time zero
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
    end

    // One transfer; payload is scrambled once taken so stale values never help
    task automatic xfer(input logic is_wr, input logic [15:0] idx, input logic [7:0] d,
                        output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        if (is_wr) begin
            awaddr  <= {idx, 2'b00};
            wdata   <= {24'h0, d};
            awvalid <= 1'b1;
            wvalid  <= 1'b1;
            bready  <= 1'b1;
        end else begin
            araddr  <= {idx, 2'b00};
            arvalid <= 1'b1;
            rready  <= 1'b1;
        end
        while (!ok && n < 50) begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) {awvalid, awaddr} <= {1'b0, ~awaddr};
            if (wvalid && wready) {wvalid, wdata} <= {1'b0, ~wdata};
            if (arvalid && arready) {arvalid, araddr} <= {1'b0, ~araddr};
            ok = is_wr ? (bready && bvalid) : (rready && rvalid);
        end
        bready <= 1'b0;
        rready <= 1'b0;
        @(posedge aclk);
    endtask : xfer
endmodule : fso_bus_host

// ---- testbench/test_flash_ram_security_options.sv ----
`timescale 1ns/1ns
// Self-checking bench for the flash and RAM security block
module test_flash_ram_security_options;
    import fso_pkg::*;
    logic         aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic         arvalid, arready, rvalid, rready, dbg_master, exec_secure;
    logic         ram_grant, ram_block, secured;
    logic [17:0]  awaddr, araddr;
    logic [31:0]  wdata, rdata, v;
    logic [3:0]   wstrb;
    logic [1:0]   bresp, rresp;
    fso_ram_req_s ram_req;
    logic [33:0]  q_bus[$];
    logic [1:0]   q_ram[$];
    int           fail_count, n_checks;

    fso_security_core DUT (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready,
        .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
        .rready, .rdata, .rresp, .dbg_master, .exec_secure, .ram_req, .ram_grant,
        .ram_block, .secured);
    fso_bus_host P (.aclk, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
        .bvalid, .bready, .arvalid, .arready, .araddr, .rvalid, .rready);

    // Clock at 125 MHz
    always #4 aclk = ~aclk;

    // Take the oldest expectation whenever a result shows up
    always @(posedge aclk) begin
        if (bvalid && bready) chk({bresp, 32'h0}, q_bus.pop_front());
        if (rvalid && rready) chk({rresp, rdata}, q_bus.pop_front());
        if (ram_grant || ram_block) chk({32'h0, ram_grant, ram_block}, {32'h0, q_ram.pop_front()});
    end

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim;
        // Expected results that never showed up count as mismatches
        fail_count += q_bus.size() + q_ram.size();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    // Bus access with its expected response noted first
    task automatic op(input logic is_wr, input logic [15:0] idx, input logic [7:0] d,
                      input logic [33:0] exp);
        logic ok;
        q_bus.push_back(exp);
        P.xfer(is_wr, idx, d, ok);
        if (!ok) begin
            fail_count++;
            end_sim();
        end
    endtask : op

    task automatic rst(input int n);
        aresetn <= 1'b0;
        repeat (n) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
    endtask : rst

    // Security level once any unlock has had time to land
    task automatic sec(input logic e);
        repeat (4) @(posedge aclk);
        chk(34'(secured), 34'(e));
    endtask : sec

    // Eight key bytes, the last one chosen by the caller
    task automatic key(input logic [7:0] last);
        for (int i = 0; i < 8; i++) op(1'b1, IDX_KEY + 16'(i), (i == 7) ? last : 8'hff, 34'h0);
    endtask : key

    // Full flash command: optional divider, address, code, launch
    task automatic cmd(input logic div, input logic [15:0] a, input logic [7:0] c);
        if (div) op(1'b1, IDX_CLK_DIV, 8'h13, 34'h0);
        op(1'b1, a, 8'h7f, 34'h0);
        op(1'b1, IDX_CMD, c, 34'h0);
        op(1'b1, IDX_STATUS, 8'h80, 34'h0);
    endtask : cmd

    // One RAM request; gate answer expected one cycle later
    task automatic ram(input logic fd, input logic cs, input logic s);
        q_ram.push_back((s && (fd || !cs)) ? 2'b01 : 2'b10);
        ram_req <= '{req: 1'b1, from_debug: fd, code_secure: cs};
        @(posedge aclk);
        ram_req.req <= 1'b0;
        @(posedge aclk);
    endtask : ram

    // Main sequence
    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        wstrb = 4'hf;
        dbg_master = 1'b0;
        exec_secure = 1'b1;
        ram_req = '0;
        fail_count = 0;
        n_checks = 0;
        v = $urandom(38);
        rst(6);
        sec(1'b1);
        op(1'b0, IDX_OPT_WORK, 8'h0, 34'hff);
        op(1'b0, IDX_PROT_WORK, 8'h0, 34'hff);
        op(1'b0, IDX_NV_OPT, 8'h0, 34'hff);
        op(1'b0, IDX_KEY + 16'h3, 8'h0, 34'hff);
        op(1'b0, 16'h1822, 8'h0, {RESP_SLVERR, 32'h0});
        // A write without its low byte lane leaves the register alone
        v = $urandom;
        wstrb <= 4'he;
        op(1'b1, IDX_PROT_WORK, 8'h00, 34'h0);
        wstrb <= 4'hf;
        op(1'b0, IDX_PROT_WORK, 8'h0, 34'hff);
        op(1'b1, IDX_PROT_WORK, v[7:0], 34'h0);
        op(1'b0, IDX_PROT_WORK, 8'h0, {26'h0, v[7:0]});
        for (int i = 0; i < 8; i++) begin
            v = $urandom;
            ram(v[0], v[1], 1'b1);
        end
        // Key from the debug port, then from unsecure code
        for (int j = 0; j < 2; j++) begin
            dbg_master <= (j == 0);
            exec_secure <= (j == 0);
            op(1'b1, IDX_CONFIG, 8'h20, 34'h0);
            key(8'hff);
            op(1'b0, IDX_STATUS, 8'h0, 34'hd0);
            sec(1'b1);
            rst(2);
        end
        dbg_master <= 1'b0;
        exec_secure <= 1'b1;
        // A wrong byte keeps the lock even against a later good key
        op(1'b1, IDX_CONFIG, 8'h20, 34'h0);
        key(8'h00);
        key(8'hff);
        sec(1'b1);
        rst(2);
        // Good key opens RAM to the debug port until reset
        op(1'b1, IDX_CONFIG, 8'h20, 34'h0);
        key(8'hff);
        sec(1'b0);
        op(1'b0, IDX_OPT_WORK, 8'h0, 34'hfe);
        ram(1'b1, 1'b0, 1'b0);
        rst(2);
        sec(1'b1);
        // Clear the key enable bit; the key no longer opens
        cmd(1'b1, IDX_NV_OPT, CMD_PROG);
        op(1'b0, IDX_NV_OPT, 8'h0, 34'h7f);
        rst(2);
        op(1'b0, IDX_OPT_WORK, 8'h0, 34'h7f);
        op(1'b1, IDX_CONFIG, 8'h20, 34'h0);
        key(8'hff);
        sec(1'b1);
        // Page erase just below the nonvolatile page leaves it alone
        cmd(1'b1, 16'hfdff, CMD_PAGE);
        op(1'b0, IDX_NV_OPT, 8'h0, 34'h7f);
        // Secured debug port may not program; the error is cleared by a one
        dbg_master <= 1'b1;
        op(1'b1, IDX_FLASH_BASE, 8'h7f, 34'h0);
        op(1'b1, IDX_CMD, CMD_PROG, 34'h0);
        op(1'b0, IDX_STATUS, 8'h0, 34'hd0);
        op(1'b1, IDX_STATUS, 8'h10, 34'h0);
        op(1'b0, IDX_STATUS, 8'h0, 34'hc0);
        // Debug port erases the array and checks it blank
        cmd(1'b0, IDX_FLASH_BASE, CMD_MASS);
        op(1'b0, IDX_NV_OPT, 8'h0, 34'hff);
        cmd(1'b0, IDX_FLASH_BASE, CMD_BLANK);
        op(1'b0, IDX_STATUS, 8'h0, 34'hc4);
        sec(1'b0);
        rst(2);
        op(1'b0, IDX_OPT_WORK, 8'h0, 34'hff);
        sec(1'b1);
        end_sim();
    end
endmodule : test_flash_ram_security_options
